// file: twr_pkg.sv
// Constants shared by the two-wire receiver and slave controller.
// Assumes the processor reaches the registers through a two-bit select port.
package twr_pkg;
  localparam logic [1:0] TWR_SEL_CONTROL = 2'h0;
  localparam logic [1:0] TWR_SEL_STATUS  = 2'h1;
  localparam logic [1:0] TWR_SEL_DATA    = 2'h2;
  localparam logic [1:0] TWR_SEL_OWNADDR = 2'h3;

  localparam int TWR_CTL_RATE2  = 7;
  localparam int TWR_CTL_ENABLE = 6;
  localparam int TWR_CTL_BEGIN  = 5;
  localparam int TWR_CTL_HALT   = 4;
  localparam int TWR_CTL_EVENT  = 3;
  localparam int TWR_CTL_ACKEN  = 2;
  localparam int TWR_CTL_RATE1  = 1;
  localparam int TWR_CTL_RATE0  = 0;

  localparam logic [7:0] TWR_CONTROL_RST = 8'h00;
  localparam logic [7:0] TWR_OWNADDR_RST = 8'h00;
  localparam logic [7:0] TWR_DATA_RST    = 8'h00;

  // Full bit periods in oscillator cycles for the fixed rate codes.
  localparam logic [13:0] TWR_DIV_000 = 14'h100;
  localparam logic [13:0] TWR_DIV_001 = 14'h0e0;
  localparam logic [13:0] TWR_DIV_010 = 14'h0c0;
  localparam logic [13:0] TWR_DIV_011 = 14'h0a0;
  localparam logic [13:0] TWR_DIV_101 = 14'h078;
  localparam logic [13:0] TWR_DIV_110 = 14'h03c;
  localparam int          TWR_TIMER_MULT = 96;
  localparam int          TWR_TIMER_TOP  = 256;

  // Status codes, stored as the five upper bits.
  localparam logic [7:0] TWR_S_BUSERR = 8'h00;
  localparam logic [7:0] TWR_S_START  = 8'h08;
  localparam logic [7:0] TWR_S_RESTRT = 8'h10;
  localparam logic [7:0] TWR_S_AW_ACK = 8'h18;
  localparam logic [7:0] TWR_S_AW_NAK = 8'h20;
  localparam logic [7:0] TWR_S_MT_ACK = 8'h28;
  localparam logic [7:0] TWR_S_MT_NAK = 8'h30;
  localparam logic [7:0] TWR_S_ARBLST = 8'h38;
  localparam logic [7:0] TWR_S_AR_ACK = 8'h40;
  localparam logic [7:0] TWR_S_AR_NAK = 8'h48;
  localparam logic [7:0] TWR_S_MR_ACK = 8'h50;
  localparam logic [7:0] TWR_S_MR_NAK = 8'h58;
  localparam logic [7:0] TWR_S_SR_OWN = 8'h60;
  localparam logic [7:0] TWR_S_SR_LST = 8'h68;
  localparam logic [7:0] TWR_S_GC_OWN = 8'h70;
  localparam logic [7:0] TWR_S_GC_LST = 8'h78;
  localparam logic [7:0] TWR_S_SR_ACK = 8'h80;
  localparam logic [7:0] TWR_S_SR_NAK = 8'h88;
  localparam logic [7:0] TWR_S_GD_ACK = 8'h90;
  localparam logic [7:0] TWR_S_GD_NAK = 8'h98;
  localparam logic [7:0] TWR_S_SR_END = 8'ha0;
  localparam logic [7:0] TWR_S_ST_OWN = 8'ha8;
  localparam logic [7:0] TWR_S_ST_LST = 8'hb0;
  localparam logic [7:0] TWR_S_ST_ACK = 8'hb8;
  localparam logic [7:0] TWR_S_ST_NAK = 8'hc0;
  localparam logic [7:0] TWR_S_ST_LAST = 8'hc8;
  localparam logic [7:0] TWR_S_NONE   = 8'hf8;

  typedef enum logic [2:0] {
    TWR_IDLE, TWR_START, TWR_BYTE, TWR_PUSH, TWR_HOLD, TWR_STOP
  } twr_state_t;
endpackage

// file: twr_ctrl.sv
// Two-wire bus controller: master receiver, slave receiver and slave transmitter,
// plus a small receive FIFO. Assumes open-drain pads resolved outside, and
// software that serves each event before the transfer can go on.
// Function
// R01: Software loads target address with read bit into data after start.
// R02: Transfer stays suspended while the event flag is set.
// R03: Address-read byte completion sets flag with 40h, 48h, 38h or slave codes.
// R04: Enable and rate-select bits are never changed by the bus logic.
// R05: After repeated start, loading address with write bit gives master transmit.
// R06: Upper seven own-address bits match; lowest bit enables general call.
// R07: Rate select affects nothing while acting as slave.
// R08: Software enables slave use with acknowledge and enable set.
// R09: Own address with write bit enters slave receive, sets flag and code.
// R10: Lost arbitration may fall into slave receive with 68h or 78h.
// R11: Acknowledge disabled during slave receive gives not-acknowledge next byte.
// R12: Acknowledge disabled ignores own address, keeps watching the bus.
// R13: Own address with read bit enters slave transmit, also after lost arbitration.
// R14: Last byte sent reports C0h or C8h, then slave releases data line.
// R15: Status reads F8h whenever the event flag is clear.
// R16: Misplaced start or stop reports 00h and sets the event flag.
// R17: Software recovers from bus error with stop request and flag clear.
// R18: Recovery clears only stop request and releases lines with no stop.
// R19: Software keeps the port latches of both lines high.
// R20: Fixed rate codes divide the oscillator by 256,224,192,160,120,60.
// R21: Code 111 uses bit period 96 times (256 minus timer reload).
// R22: Status code sits in five upper bits, lower three read zero.
// R23: Status appears and vanishes one cycle after the event flag.
// R24: Hardware reset disables the module.
// R25: While flagged as master or addressed slave, the clock line is held low.
`timescale 1ns/1ps

module twr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             load;

  assign in_ready_out = (count != CW'(DEPTH));
  assign push         = in_valid_in & in_ready_out;
  // The output word is registered, so the head leaves the array before it is taken.
  assign load         = (count != '0) & (!out_valid_out | out_ready_in);

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (load) begin
        rd_ptr        <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
        out_data_out  <= mem[rd_ptr];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      count <= count + CW'(push) - CW'(load);
    end
  end
endmodule

module twr_ctrl
  import twr_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic [1:0] sfr_sel_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic [7:0] timer1_reload_in,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_b_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in
);
  logic [7:0]  control;
  logic [7:0]  own_addr;
  logic [7:0]  data_q;
  logic [4:0]  code;
  logic        si_dly;
  logic        scl_s1, scl_s2, scl_q;
  logic        sda_s1, sda_s2, sda_q;
  logic        busy;
  twr_state_t  state;
  logic [1:0]  step;
  logic [3:0]  idx;
  logic [7:0]  shreg;
  logic        master, addressed, lost, tx, is_addr, gcall, last_byte, ack_ok, rep;
  logic        set_si, clr_sto, push;
  logic [13:0] cnt;
  logic [13:0] half;
  logic [7:0]  next_code;
  logic        fifo_ready;
  logic        line_low;

  wire en        = control[TWR_CTL_ENABLE];
  wire si        = control[TWR_CTL_EVENT];
  wire acken     = control[TWR_CTL_ACKEN];
  wire scl_rise  = scl_s2 & !scl_q;
  wire scl_fall  = !scl_s2 & scl_q;
  wire start_bus = scl_s2 & scl_q & sda_q & !sda_s2;
  wire stop_bus  = scl_s2 & scl_q & !sda_q & sda_s2;
  wire part      = master | addressed | lost;
  wire match_own = acken & (shreg[7:1] == own_addr[7:1]);                  // see R06 see R12
  wire match_gc  = acken & own_addr[0] & (shreg[7:1] == 7'h00) & !shreg[0]; // see R06
  wire drives    = (state == TWR_START) | (state == TWR_STOP) | ((state == TWR_BYTE) & master);
  wire tick      = drives & (cnt >= half - 14'h1);
  wire rx_data   = !is_addr & !tx & (master | addressed);
  wire halt_req  = control[TWR_CTL_HALT];
  wire begin_req = control[TWR_CTL_BEGIN];
  wire resume    = !si & !set_si;

  function automatic logic [13:0] twr_half(input logic [2:0] rate, input logic [7:0] reload);
    case (rate)
      3'h1:    return TWR_DIV_001 >> 1;
      3'h2:    return TWR_DIV_010 >> 1;
      3'h3:    return TWR_DIV_011 >> 1;
      3'h5:    return TWR_DIV_101 >> 1;
      3'h6:    return TWR_DIV_110 >> 1;
      3'h7:    return 14'((TWR_TIMER_MULT / 2) * (TWR_TIMER_TOP - int'(reload))); // see R21
      default: return TWR_DIV_000 >> 1; // see R20
    endcase
  endfunction

  // Only the master path counts half periods, so the rate is dead in slave use.
  assign half = twr_half({control[TWR_CTL_RATE2], control[TWR_CTL_RATE1],
                          control[TWR_CTL_RATE0]}, timer1_reload_in); // see R07 see R20

  always_comb begin
    if (lost & !addressed) begin
      next_code = TWR_S_ARBLST;
    end else if (is_addr & master) begin
      next_code = shreg[0] ? (ack_ok ? TWR_S_AR_ACK : TWR_S_AR_NAK)            // see R03
                           : (ack_ok ? TWR_S_AW_ACK : TWR_S_AW_NAK);
    end else if (is_addr) begin
      next_code = shreg[0] ? (lost ? TWR_S_ST_LST : TWR_S_ST_OWN)               // see R13
                : gcall    ? (lost ? TWR_S_GC_LST : TWR_S_GC_OWN)               // see R10
                           : (lost ? TWR_S_SR_LST : TWR_S_SR_OWN);              // see R09
    end else if (master) begin
      next_code = tx ? (ack_ok ? TWR_S_MT_ACK : TWR_S_MT_NAK)
                     : (ack_ok ? TWR_S_MR_ACK : TWR_S_MR_NAK);
    end else if (tx) begin
      next_code = !ack_ok ? TWR_S_ST_NAK : (last_byte ? TWR_S_ST_LAST : TWR_S_ST_ACK); // see R14
    end else begin
      next_code = gcall ? (ack_ok ? TWR_S_GD_ACK : TWR_S_GD_NAK)
                        : (ack_ok ? TWR_S_SR_ACK : TWR_S_SR_NAK);
    end
  end

  // Both lines come from the pads; the first stage is read by the second only.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_q  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_q  <= sda_s2;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= '0;
    end else if (!drives || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 14'h1;
    end
  end

  // Software may only clear the event flag; a hardware set in the same cycle wins.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control <= TWR_CONTROL_RST; // see R24
    end else if (sfr_wr_in && sfr_sel_in == TWR_SEL_CONTROL) begin
      control                <= sfr_wdata_in;
      control[TWR_CTL_EVENT] <= set_si | (si & sfr_wdata_in[TWR_CTL_EVENT]);
    end else begin
      control[TWR_CTL_EVENT] <= si | set_si;
      control[TWR_CTL_HALT]  <= halt_req & !clr_sto; // see R04 see R18
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      own_addr <= TWR_OWNADDR_RST;
    end else if (sfr_wr_in && sfr_sel_in == TWR_SEL_OWNADDR) begin
      own_addr <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      si_dly        <= 1'b0;
      sfr_rdata_out <= 8'h00;
      line_low      <= 1'b0;
    end else begin
      si_dly   <= si; // see R23
      line_low <= 1'b0;
      case (sfr_sel_in)
        TWR_SEL_CONTROL: sfr_rdata_out <= control;
        TWR_SEL_STATUS:  sfr_rdata_out <= si_dly ? {code, 3'h0} : TWR_S_NONE; // see R15 see R22
        TWR_SEL_DATA:    sfr_rdata_out <= data_q;
        default:         sfr_rdata_out <= own_addr;
      endcase
    end
  end

  assign scl_out = line_low;
  assign sda_out = line_low;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= TWR_IDLE;
      {step, idx, shreg, data_q, code} <= {2'h0, 4'h0, 8'h00, TWR_DATA_RST, 5'h00};
      {master, addressed, lost, tx, is_addr, gcall, last_byte, ack_ok, rep} <= 9'h000;
      {set_si, clr_sto, push, busy} <= 4'h0;
      scl_oe_b_out <= 1'b1;
      sda_oe_b_out <= 1'b1;
    end else begin
      set_si  <= 1'b0;
      clr_sto <= 1'b0;
      push    <= 1'b0;
      if (sfr_wr_in && sfr_sel_in == TWR_SEL_DATA) begin
        data_q <= sfr_wdata_in;
      end
      if (start_bus) begin
        busy <= 1'b1;
      end else if (stop_bus) begin
        busy <= 1'b0;
      end
      if (!en) begin
        state <= TWR_IDLE;
        {master, addressed, lost} <= 3'h0;
        scl_oe_b_out <= 1'b1;
        sda_oe_b_out <= 1'b1;
      end else begin
        unique case (state)
          TWR_IDLE: begin
            scl_oe_b_out <= 1'b1;
            sda_oe_b_out <= 1'b1;
            if (begin_req && !busy && resume) begin
              state  <= TWR_START;
              step   <= 2'h1;
              master <= 1'b1;
              lost   <= 1'b0;
              rep    <= 1'b0;
            end else if (start_bus) begin
              state <= TWR_BYTE;
              {idx, is_addr, tx, addressed, lost} <= {4'h0, 1'b1, 3'h0};
            end
          end
          TWR_START: begin
            if (tick) begin
              unique case (step)
                2'h0: begin
                  scl_oe_b_out <= 1'b1;
                  step         <= 2'h1;
                end
                2'h1: begin
                  if (scl_s2) begin
                    sda_oe_b_out <= 1'b0;
                    step         <= 2'h2;
                  end
                end
                2'h2: begin
                  scl_oe_b_out <= 1'b0;
                  step         <= 2'h3;
                end
                default: begin
                  code   <= rep ? TWR_S_RESTRT[7:3] : TWR_S_START[7:3];
                  set_si <= 1'b1;
                  state  <= TWR_HOLD;
                end
              endcase
            end
          end
          TWR_BYTE: begin
            if ((start_bus || stop_bus) && part && idx != 4'h0) begin
              code   <= TWR_S_BUSERR[7:3]; // see R16
              set_si <= 1'b1;
              state  <= TWR_HOLD;
              {master, addressed, lost} <= 3'h0;
              scl_oe_b_out <= 1'b1;
              sda_oe_b_out <= 1'b1;
            end else if (start_bus && !master) begin
              {idx, is_addr, tx, addressed, lost} <= {4'h0, 1'b1, 3'h0};
              sda_oe_b_out <= 1'b1;
            end else if (stop_bus && !master) begin
              // A stop ends the slave for good, so the clock is never stretched here.
              if (addressed) begin
                code   <= TWR_S_SR_END[7:3];
                set_si <= 1'b1;
                state  <= TWR_HOLD;
              end else begin
                state <= TWR_IDLE;
              end
              addressed    <= 1'b0;
              sda_oe_b_out <= 1'b1;
            end else begin
              if (master && tick && (!scl_oe_b_out || scl_s2)) begin
                scl_oe_b_out <= !scl_oe_b_out;
              end
              if (scl_rise && idx < 4'h9) begin
                idx <= idx + 4'h1;
                if (idx < 4'h8) begin
                  shreg <= {shreg[6:0], sda_s2};
                  if (master && tx && sda_oe_b_out && !sda_s2) begin
                    {lost, master, tx} <= 3'h4; // see R10 see R13
                    scl_oe_b_out <= 1'b1;
                  end
                end else begin
                  ack_ok <= !sda_s2;
                end
              end
              if (scl_fall) begin
                if (idx == 4'h8) begin
                  if (is_addr && !master) begin
                    if (match_own || match_gc) begin
                      addressed    <= 1'b1;
                      gcall        <= match_gc;
                      tx           <= shreg[0];
                      sda_oe_b_out <= 1'b0;
                    end else begin
                      sda_oe_b_out <= 1'b1;
                      if (!lost) begin
                        state <= TWR_IDLE;
                      end
                    end
                  end else if (is_addr || tx) begin
                    sda_oe_b_out <= 1'b1;
                    if (is_addr) begin
                      tx <= !shreg[0]; // see R05
                    end
                  end else begin
                    sda_oe_b_out <= !acken; // see R11
                  end
                end else if (idx == 4'h9) begin
                  state        <= TWR_PUSH;
                  scl_oe_b_out <= !(master || addressed);
                  sda_oe_b_out <= 1'b1;
                end else begin
                  sda_oe_b_out <= tx ? shreg[7] : 1'b1;
                end
              end
            end
          end
          TWR_PUSH: begin
            scl_oe_b_out <= !(master || addressed);
            if (!rx_data || fifo_ready) begin
              push    <= rx_data;
              data_q  <= shreg;
              code    <= next_code[7:3];
              set_si  <= 1'b1; // see R03 see R09
              is_addr <= 1'b0;
              state   <= TWR_HOLD;
            end
          end
          TWR_HOLD: begin
            scl_oe_b_out <= !(master || addressed); // see R25
            if (resume) begin // see R02
              if (halt_req && master) begin
                state        <= TWR_STOP;
                step         <= 2'h0;
                sda_oe_b_out <= 1'b0;
              end else if (halt_req) begin
                clr_sto <= 1'b1; // see R17 see R18
                {addressed, lost} <= 2'h0;
                state   <= TWR_IDLE;
              end else if (begin_req && master) begin
                state        <= TWR_START;
                step         <= 2'h0;
                rep          <= 1'b1;
                sda_oe_b_out <= 1'b1;
              end else if (!master && (!addressed || code == TWR_S_ST_NAK[7:3] ||
                           code == TWR_S_ST_LAST[7:3] || code == TWR_S_SR_NAK[7:3] ||
                           code == TWR_S_GD_NAK[7:3])) begin
                {addressed, lost} <= 2'h0; // see R14
                state <= TWR_IDLE;
              end else begin
                state <= TWR_BYTE;
                scl_oe_b_out <= !master; // see R25
                idx   <= 4'h0;
                if (code == TWR_S_START[7:3] || code == TWR_S_RESTRT[7:3] || tx) begin
                  shreg        <= data_q; // see R01
                  sda_oe_b_out <= data_q[7];
                  last_byte    <= !acken;
                  if (code == TWR_S_START[7:3] || code == TWR_S_RESTRT[7:3]) begin
                    is_addr <= 1'b1;
                    tx      <= 1'b1;
                  end
                end else begin
                  sda_oe_b_out <= 1'b1;
                end
              end
            end
          end
          TWR_STOP: begin
            if (tick) begin
              if (step == 2'h0) begin
                scl_oe_b_out <= 1'b1;
                step         <= 2'h1;
              end else if (step == 2'h1) begin
                if (scl_s2) begin
                  sda_oe_b_out <= 1'b1;
                  step         <= 2'h2;
                end
              end else begin
                clr_sto <= 1'b1;
                master  <= 1'b0;
                state   <= TWR_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  twr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (data_q),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );
endmodule

// file: twr_asserts.sv
// Checker on the top-level ports of the two-wire controller.
// Assumes the bench keeps the block in slave roles and starts it in reset.
`timescale 1ns/1ps
module twr_asserts
  import twr_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic [1:0] sfr_sel_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       scl_in,
  input wire logic       scl_oe_b_out,
  input wire logic       sda_oe_b_out,
  input wire logic [7:0] rx_data_out,
  input wire logic       rx_valid_out,
  input wire logic       rx_ready_in
);
  logic       ctl_wr;
  logic       en_seen;
  logic [3:0] quiet;
  assign ctl_wr = sfr_wr_in && sfr_sel_in == TWR_SEL_CONTROL;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) en_seen <= 1'b0;
    else if (ctl_wr && sfr_wdata_in[TWR_CTL_ENABLE]) en_seen <= 1'b1;
  end
  // A stretch may end some cycles after a control write or a FIFO pop, so wait those out.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) quiet <= 4'h0;
    else if (ctl_wr || (rx_valid_out && rx_ready_in)) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence stretching;
    !scl_oe_b_out && quiet > 4'h8;
  endsequence
  sequence flag_cleared;
    ctl_wr && !sfr_wdata_in[TWR_CTL_EVENT] && !scl_oe_b_out;
  endsequence
  AST_OFF_FREE: assert property (!en_seen |-> scl_oe_b_out && sda_oe_b_out)
    else $error("line pulled while disabled");
  AST_LOW_ZERO: assert property (
    $past(sfr_sel_in) == TWR_SEL_STATUS |-> sfr_rdata_out[2:0] == 3'h0)
    else $error("status low bits set");
  AST_NONE_IDLE: assert property ($past(rst_b_in) && !$past(en_seen) &&
    $past(sfr_sel_in) == TWR_SEL_STATUS |-> sfr_rdata_out == TWR_S_NONE)
    else $error("idle status wrong");
  AST_RATE_KEPT: assert property ($past(sfr_sel_in) == TWR_SEL_CONTROL &&
    $past(sfr_sel_in, 2) == TWR_SEL_CONTROL && !$past(sfr_wr_in, 2)
    |-> $stable(sfr_rdata_out[7:6]) && $stable(sfr_rdata_out[1:0]))
    else $error("enable or rate bits moved");
  AST_HOLD: assert property (stretching |=> !scl_oe_b_out)
    else $error("clock stretch ended early");
  AST_RELEASE: assert property (flag_cleared |-> ##[1:8] scl_oe_b_out)
    else $error("clock not released");
  AST_SDA_GRAB: assert property ($fell(sda_oe_b_out) |-> !scl_in)
    else $error("data pulled with clock high");
  AST_RX_HOLD: assert property (
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("receive head dropped");
endmodule
bind twr_ctrl twr_asserts u_asserts (.*);

// file: twr_bus_master.sv
// Model of another master on the two-wire bus, driven by the bench's tasks.
// Assumes pulled-up open-drain lines; one bit takes 32 oscillator cycles.
`timescale 1ns/1ps
module twr_bus_master (
  input  wire logic clock_in,
  input  wire logic scl_oe_b_in,
  input  wire logic sda_oe_b_in,
  output wire logic scl_line_out,
  output wire logic sda_line_out
);
  logic scl_b = 1'b1;
  logic sda_b = 1'b1;
  assign scl_line_out = scl_b & scl_oe_b_in;
  assign sda_line_out = sda_b & sda_oe_b_in;
  task automatic gap();
    repeat (8) @(negedge clock_in);
  endtask
  // Waiting on the line, not on our own drive, lets the slave stretch the clock.
  task automatic rise();
    scl_b = 1'b1;
    for (int n = 0; n < 4000 && !scl_line_out; n++) @(negedge clock_in);
    gap();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_b = b;
    gap();
    rise();
    s = sda_line_out;
    gap();
    scl_b = 1'b0;
    gap();
  endtask
  task automatic start();
    sda_b = 1'b0;
    gap();
    scl_b = 1'b0;
  endtask
  task automatic stop();
    sda_b = 1'b0;
    gap();
    rise();
    sda_b = 1'b1;
    gap();
  endtask
  task automatic put(input logic [7:0] d, input logic mack, output logic [7:0] q,
                     output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, ack);
  endtask
endmodule

// file: twr_ctrl_bench.sv
// Self-checking bench for the two-wire controller in its slave roles.
// Assumes the bus master model is the only other party on the lines.
`timescale 1ns/1ps
module twr_ctrl_bench
  import twr_pkg::*;
;
  logic       clk, rst_b, wr, scl, sda, scl_oe_b, sda_oe_b, rx_valid, rx_ready, ack;
  logic [1:0] sel;
  logic [7:0] wdata, rdata, rx_data, q;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cycles = 0;
  twr_ctrl DUT (.clock_in(clk), .rst_b_in(rst_b), .sfr_sel_in(sel), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer1_reload_in(8'h00), .scl_in(scl),
    .scl_out(), .scl_oe_b_out(scl_oe_b), .sda_in(sda), .sda_out(), .sda_oe_b_out(sda_oe_b),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
  twr_bus_master bus (.clock_in(clk), .scl_oe_b_in(scl_oe_b), .sda_oe_b_in(sda_oe_b),
    .scl_line_out(scl), .sda_line_out(sda));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    {sel, wdata, wr} = {s, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [1:0] s, input logic [7:0] exp);
    @(negedge clk);
    sel = s;
    repeat (2) @(negedge clk);
    chk8($sformatf("register %0d", s), exp, rdata);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, input logic [7:0] eq,
                      input logic ea);
    bus.put(d, mack, q, ack);
    chk8("bus byte", eq, q);
    chk8("bus ack", {7'h00, ea}, {7'h00, ack});
  endtask
  task automatic t_slave_rx();
    rreg(TWR_SEL_CONTROL, TWR_CONTROL_RST);
    rreg(TWR_SEL_STATUS, TWR_S_NONE);
    wreg(TWR_SEL_OWNADDR, 8'ha4);
    wreg(TWR_SEL_CONTROL, 8'h44);
    bus.start();
    xfer(8'ha4, 1'b1, 8'ha4, 1'b0);
    chk8("stretch", 8'h00, {7'h00, scl_oe_b});
    rreg(TWR_SEL_STATUS, TWR_S_SR_OWN);
    wreg(TWR_SEL_CONTROL, 8'h44);
    xfer(8'h3c, 1'b1, 8'h3c, 1'b0);
    rreg(TWR_SEL_STATUS, TWR_S_SR_ACK);
    wreg(TWR_SEL_CONTROL, 8'h40);
    xfer(8'hc3, 1'b1, 8'hc3, 1'b1);
    rreg(TWR_SEL_STATUS, TWR_S_SR_NAK);
    chk8("rx valid", 8'h01, {7'h00, rx_valid});
    chk8("fifo head", 8'h3c, rx_data);
    rx_ready = 1'b1;
    wreg(TWR_SEL_CONTROL, 8'h40);
    bus.stop();
  endtask
  task automatic t_ignore();
    bus.start();
    xfer(8'ha4, 1'b1, 8'ha4, 1'b1);
    bus.stop();
    wreg(TWR_SEL_CONTROL, 8'h44);
    bus.start();
    xfer(8'h00, 1'b1, 8'h00, 1'b1);
    bus.stop();
    bus.start();
    xfer(8'ha4, 1'b1, 8'ha4, 1'b0);
    wreg(TWR_SEL_CONTROL, 8'h44);
    // A stop after three data bits lands in the middle of a byte.
    repeat (3) bus.bit_io(1'b0, ack);
    bus.stop();
    rreg(TWR_SEL_STATUS, TWR_S_BUSERR);
    wreg(TWR_SEL_CONTROL, 8'h54);
    rreg(TWR_SEL_CONTROL, 8'h44);
    chk8("lines", 8'h03, {6'h00, scl_oe_b, sda_oe_b});
    rreg(TWR_SEL_STATUS, TWR_S_NONE);
  endtask
  task automatic t_slave_tx();
    bus.start();
    xfer(8'ha5, 1'b1, 8'ha5, 1'b0);
    rreg(TWR_SEL_STATUS, TWR_S_ST_OWN);
    wreg(TWR_SEL_DATA, 8'h96);
    wreg(TWR_SEL_CONTROL, 8'h40);
    xfer(8'hff, 1'b1, 8'h96, 1'b1);
    rreg(TWR_SEL_STATUS, TWR_S_ST_NAK);
    wreg(TWR_SEL_CONTROL, 8'h44);
    xfer(8'hff, 1'b0, 8'hff, 1'b0);
    bus.stop();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_b, wr, rx_ready, sel, wdata} = '0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    t_slave_rx();
    t_ignore();
    t_slave_tx();
    tally_and_finish();
  end
endmodule
